// ===== hdl/hso_regs.svh
// constants for the hit sparsifier and output buffer stage
`ifndef HSO_REGS_SVH
`define HSO_REGS_SVH
`define HSO_NUM_CHANNELS 256
`define HSO_ADDR_W 8
`define HSO_AMP_W 8
`define HSO_LEN_W 9
`define HSO_HIT_W 16
`define HSO_HDR_W 32
`define HSO_DATA_DEPTH 512
`define HSO_SIDE_DEPTH 16
`define HSO_LATENCY_CYCLES 512
`define HSO_HDR_ID_LSB 24
`define HSO_HDR_STATUS_LSB 16
`define HSO_HDR_TYPE_LSB 8
`define HSO_HDR_HIST_LSB 0
`define HSO_STATUS_OVERFLOW 8'h01
`define HSO_TYPE_ZERO_SUPPRESSED 8'h01
`endif

// ===== hdl/hso_pkg.sv
// types shared by the hit sparsifier and output buffer stage
`include "hso_regs.svh"
package hso_pkg;
  typedef struct packed {
    logic [`HSO_ADDR_W-1:0] strip;
    logic [`HSO_AMP_W-1:0] amp;
  } hso_hit_type;

  typedef struct packed {
    logic [7:0] chan_id;
    logic [7:0] status;
    logic [7:0] kind;
    logic [7:0] history;
  } hso_header_type;

  typedef enum logic [1:0] {
    HSO_IDLE,
    HSO_FRAME,
    HSO_WAIT,
    HSO_COMMIT
  } hso_phase_type;
endpackage : hso_pkg

// ===== hdl/hso_fifo.sv
// synchronous fifo used for the hit, length and header buffers
`timescale 1ns/10ps
module hso_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  output logic [WIDTH-1:0] rd_data,
  output logic empty,
  output logic full,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic do_wr;
  logic do_rd;

  // writes to a full fifo and reads from an empty one are dropped
  assign do_wr = wr_en && (cnt_q != DEPTH[AW:0]);
  assign do_rd = rd_en && (cnt_q != '0);
  assign empty = (cnt_q == '0);
  assign full = (cnt_q == DEPTH[AW:0]);
  assign count = cnt_q;
  assign rd_data = mem[rp_q];

  // storage has no reset, pointers do
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : AW'(wp_q + 1'b1);
      end
      if (do_rd) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : AW'(rp_q + 1'b1);
      end
      if (do_wr && !do_rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : hso_fifo

// ===== hdl/hso_sparsifier.sv
// hit finding, address tagging and three output fifos for one channel
`timescale 1ns/10ps
`include "hso_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module hso_sparsifier
  import hso_pkg::*;
#(
  parameter int NUM_CHANNELS = `HSO_NUM_CHANNELS,
  parameter int DATA_DEPTH = `HSO_DATA_DEPTH,
  parameter int SIDE_DEPTH = `HSO_SIDE_DEPTH,
  parameter int LATENCY = `HSO_LATENCY_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic FRAME_START,
  input wire logic SAMPLE_VALID,
  input wire logic [`HSO_AMP_W-1:0] SAMPLE,
  input wire logic [`HSO_AMP_W-1:0] THRESHOLD,
  input wire logic [7:0] CHAN_ID,
  input wire logic [7:0] HISTORY,
  input wire logic DATA_POP,
  input wire logic LEN_POP,
  input wire logic HDR_POP,
  output logic [`HSO_HIT_W-1:0] DATA_OUT,
  output logic DATA_EMPTY,
  output logic [`HSO_LEN_W-1:0] LEN_OUT,
  output logic LEN_EMPTY,
  output logic [`HSO_HDR_W-1:0] HDR_OUT,
  output logic HDR_EMPTY,
  output logic OVERFLOW
);
  localparam int CW = $clog2(NUM_CHANNELS + 1);
  localparam int LW = $clog2(LATENCY + 1);
  // chan has a spare bit so the last-channel compare cannot wrap
  // lat runs down from the frame start in every phase; one or less means due

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    // frame bookkeeping
    hso_phase_type phase;
    logic [CW-1:0] chan;
    logic [`HSO_LEN_W-1:0] hits;
    logic [LW-1:0] lat;
    logic ovf;
    logic [7:0] hist;
    // one-cycle write strobes and the words they carry
    logic wr_data;
    hso_hit_type hit;
    logic wr_side;
    logic [`HSO_LEN_W-1:0] len;
    hso_header_type hdr;
    // registered copies of the fifo heads and flags
    logic [`HSO_HIT_W-1:0] data_out;
    logic data_empty;
    logic [`HSO_LEN_W-1:0] len_out;
    logic len_empty;
    logic [`HSO_HDR_W-1:0] hdr_out;
    logic hdr_empty;
    logic overflow;
  } hso_state_type;

  hso_state_type s_q;
  hso_state_type s_d;

  // fifo heads and status read by the next-state logic
  logic [`HSO_HIT_W-1:0] dfifo_q;
  logic [`HSO_LEN_W-1:0] lfifo_q;
  logic [`HSO_HDR_W-1:0] hfifo_q;
  logic dfifo_empty;
  logic lfifo_empty;
  logic hfifo_empty;
  logic dfifo_full;
  logic lfifo_full;
  logic hfifo_full;
  logic [$clog2(DATA_DEPTH):0] dfifo_count;

  // a sample is a hit when it strictly exceeds its threshold
  // used for the start sample and for every later one
  function automatic logic is_hit(input logic [`HSO_AMP_W-1:0] v,
                                  input logic [`HSO_AMP_W-1:0] t);
    return v > t;
  endfunction : is_hit

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole stage
  always_comb begin
    s_d = s_q;
    s_d.wr_data = 1'b0;
    s_d.wr_side = 1'b0;
    if (s_q.lat != '0) begin
      s_d.lat = LW'(s_q.lat - 1'b1);
    end
    case (s_q.phase)
      HSO_IDLE: begin
        if (FRAME_START && SAMPLE_VALID) begin
          s_d.phase = HSO_FRAME;
          s_d.chan = CW'(1);
          s_d.ovf = 1'b0;
          s_d.hist = HISTORY;
          s_d.lat = LW'(LATENCY - 1);
          // first sample of the frame arrives with the start pulse
          if (is_hit(SAMPLE, THRESHOLD)) begin
            // a data fifo left full by an unread earlier event refuses the hit
            if (dfifo_full) begin
              s_d.ovf = 1'b1;
              s_d.hits = '0;
            end else begin
              s_d.wr_data = 1'b1;
              s_d.hit = '{strip: '0, amp: SAMPLE};
              s_d.hits = `HSO_LEN_W'(1);
            end
          end else begin
            s_d.hits = '0;
          end
        end
      end
      HSO_FRAME: begin
        // start pulses in mid-frame are ignored; the channel count ends it
        if (SAMPLE_VALID) begin
          if (is_hit(SAMPLE, THRESHOLD)) begin
            // a hit that finds the data fifo full sets the overflow flag and is not stored
            if (dfifo_full || (s_q.wr_data && dfifo_count == DATA_DEPTH - 1)) begin
              s_d.ovf = 1'b1;
            end else begin
              s_d.wr_data = 1'b1;
              s_d.hit = '{strip: `HSO_ADDR_W'(s_q.chan), amp: SAMPLE};
              s_d.hits = `HSO_LEN_W'(s_q.hits + 1'b1);
            end
          end
          if (s_q.chan == CW'(NUM_CHANNELS - 1)) begin
            s_d.phase = HSO_WAIT;
          end
          s_d.chan = CW'(s_q.chan + 1'b1);
        end
      end
      HSO_WAIT: begin
        // a frame stretched by gaps past the latency commits at once, later than nominal
        // hold the commit back to the fixed output latency
        if (s_q.lat <= LW'(1)) begin
          s_d.phase = HSO_COMMIT;
        end
      end
      HSO_COMMIT: begin
        // side fifos are sized for whole events; a full one stalls commit
        if (!lfifo_full && !hfifo_full) begin
          s_d.wr_side = 1'b1;
          s_d.len = s_q.hits;
          // the trailer is left to the readout side; the header is one word
          s_d.hdr.chan_id = CHAN_ID;
          s_d.hdr.status = s_q.ovf ? `HSO_STATUS_OVERFLOW : 8'h00;
          s_d.hdr.kind = `HSO_TYPE_ZERO_SUPPRESSED;
          s_d.hdr.history = s_q.hist;
          s_d.phase = HSO_IDLE;
        end
      end
      default: begin
        s_d.phase = HSO_IDLE;
      end
    endcase
    // registered copies of the fifo heads keep outputs flop-driven
    s_d.data_out = dfifo_q;
    s_d.data_empty = dfifo_empty;
    s_d.len_out = lfifo_q;
    s_d.len_empty = lfifo_empty;
    s_d.hdr_out = hfifo_q;
    s_d.hdr_empty = hfifo_empty;
    s_d.overflow = s_q.ovf;
  end

  // state register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_q <= '0;
      s_q.phase <= HSO_IDLE;
      s_q.data_empty <= 1'b1;
      s_q.len_empty <= 1'b1;
      s_q.hdr_empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffers; reader pops length and header then the hit words
  hso_fifo #(.WIDTH(`HSO_HIT_W), .DEPTH(DATA_DEPTH)) u_data_fifo (
    .clk(CLK), .reset(RESET), .wr_en(s_q.wr_data), .wr_data(s_q.hit),
    .rd_en(DATA_POP), .rd_data(dfifo_q), .empty(dfifo_empty),
    .full(dfifo_full), .count(dfifo_count)
  );

  // length and header are written in the same cycle, so they stay paired
  hso_fifo #(.WIDTH(`HSO_LEN_W), .DEPTH(SIDE_DEPTH)) u_len_fifo (
    .clk(CLK), .reset(RESET), .wr_en(s_q.wr_side), .wr_data(s_q.len),
    .rd_en(LEN_POP), .rd_data(lfifo_q), .empty(lfifo_empty),
    .full(lfifo_full), .count()
  );

  hso_fifo #(.WIDTH(`HSO_HDR_W), .DEPTH(SIDE_DEPTH)) u_hdr_fifo (
    .clk(CLK), .reset(RESET), .wr_en(s_q.wr_side), .wr_data(s_q.hdr),
    .rd_en(HDR_POP), .rd_data(hfifo_q), .empty(hfifo_empty),
    .full(hfifo_full), .count()
  );

  // every port is a copy held in the state register
  assign DATA_OUT = s_q.data_out;
  assign DATA_EMPTY = s_q.data_empty;
  assign LEN_OUT = s_q.len_out;
  assign LEN_EMPTY = s_q.len_empty;
  assign HDR_OUT = s_q.hdr_out;
  assign HDR_EMPTY = s_q.hdr_empty;
  assign OVERFLOW = s_q.overflow;
endmodule : hso_sparsifier

// ===== test/hso_sparsifier_asserts.sv
// port checker for the hit sparsifier
`timescale 1ns/10ps
`include "hso_regs.svh"
module hso_sparsifier_asserts #(
  parameter int LATENCY = 512
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic FRAME_START,
  input wire logic SAMPLE_VALID,
  input wire logic [7:0] SAMPLE,
  input wire logic [7:0] THRESHOLD,
  input wire logic DATA_POP,
  input wire logic [15:0] DATA_OUT,
  input wire logic DATA_EMPTY,
  input wire logic LEN_EMPTY,
  input wire logic [31:0] HDR_OUT,
  input wire logic HDR_EMPTY
);
  localparam int LO = LATENCY;
  localparam int HI = LATENCY + 8;
  wire logic hit = SAMPLE_VALID && SAMPLE > THRESHOLD;
  wire logic go = FRAME_START && SAMPLE_VALID;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  ////////////////
  // earlier hits in flight would own the head, so only a lone hit counts
  sequence first_hit;
    hit && DATA_EMPTY && !$past(hit) && !$past(hit, 2);
  endsequence
  hit_stored_a: assert property (first_hit |-> ##3 !DATA_EMPTY)
    else $error("hit not stored");
  hit_amp_a: assert property (first_hit |-> ##3 DATA_OUT[7:0] == $past(SAMPLE, 3))
    else $error("hit amplitude wrong");
  no_hit_a: assert property ((DATA_EMPTY && !hit)[*3] |=> DATA_EMPTY)
    else $error("non-hit stored");
  // head holds while nobody pops
  head_hold_a: assert property (!DATA_EMPTY && !DATA_POP && !$past(DATA_POP)
    && !$past(DATA_POP, 2) |=> $stable(DATA_OUT)) else $error("head moved");
  // length and header land together, a fixed time after the start
  len_latency_a: assert property (go && LEN_EMPTY |-> ##[LO:HI] !LEN_EMPTY)
    else $error("length late");
  len_hdr_pair_a: assert property ($fell(LEN_EMPTY) |-> $fell(HDR_EMPTY))
    else $error("header not paired");
  hdr_type_a: assert property (!HDR_EMPTY |-> HDR_OUT[15:8] == `HSO_TYPE_ZERO_SUPPRESSED)
    else $error("header type wrong");
  empty_reset_a: assert property ($fell(RESET) |-> DATA_EMPTY && LEN_EMPTY && HDR_EMPTY)
    else $error("fifos not empty");
  cover property (first_hit);
  cover property ($fell(LEN_EMPTY));
  cover property (DATA_POP && !DATA_EMPTY);
endmodule : hso_sparsifier_asserts
bind hso_sparsifier hso_sparsifier_asserts #(.LATENCY(LATENCY)) chk (
  .CLK(CLK), .RESET(RESET), .FRAME_START(FRAME_START), .SAMPLE_VALID(SAMPLE_VALID),
  .SAMPLE(SAMPLE), .THRESHOLD(THRESHOLD), .DATA_POP(DATA_POP), .DATA_OUT(DATA_OUT),
  .DATA_EMPTY(DATA_EMPTY), .LEN_EMPTY(LEN_EMPTY), .HDR_OUT(HDR_OUT), .HDR_EMPTY(HDR_EMPTY)
);

// ===== test/hso_reader.sv
// readout partner draining one event from the three fifos
`timescale 1ns/10ps
module hso_reader (
  input wire logic CLK,
  input wire logic [8:0] LEN_OUT,
  input wire logic [31:0] HDR_OUT,
  input wire logic [15:0] DATA_OUT,
  output logic DATA_POP = 1'b0,
  output logic LEN_POP = 1'b0,
  output logic HDR_POP = 1'b0
);
  logic [15:0] words [0:255];
  ////////////////
  // one pop pulse, then two cycles for the registered head to settle
  task automatic pop_one(input logic data);
    @(posedge CLK);
    DATA_POP <= data;
    LEN_POP <= !data;
    HDR_POP <= !data;
    @(posedge CLK);
    DATA_POP <= 1'b0;
    LEN_POP <= 1'b0;
    HDR_POP <= 1'b0;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
  endtask : pop_one
  // length and header first, then exactly that many words
  task automatic read_event(output logic [8:0] n, output logic [31:0] h);
    @(negedge CLK);
    n = LEN_OUT;
    h = HDR_OUT;
    pop_one(1'b0);
    for (int i = 0; i < n; i++) begin
      words[i] = DATA_OUT;
      pop_one(1'b1);
    end
  endtask : read_event
endmodule : hso_reader

// ===== test/test_hit_sparsifier_output_buffers.sv
// self-checking bench for the hit sparsifier
`timescale 1ns/10ps
`include "hso_regs.svh"
module test_hit_sparsifier_output_buffers;
  localparam int LAT = 300;
  // a shallow data fifo lets one frame overrun it in a short run
  localparam int DEPTH = 16;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic FRAME_START = 1'b0;
  logic SAMPLE_VALID = 1'b0;
  logic [7:0] SAMPLE = 8'h00;
  logic [7:0] THRESHOLD = 8'h00;
  logic [7:0] CHAN_ID = 8'hC3;
  logic [7:0] HISTORY = 8'h00;
  logic DATA_POP, LEN_POP, HDR_POP, DATA_EMPTY, LEN_EMPTY, HDR_EMPTY, OVERFLOW;
  logic [15:0] DATA_OUT;
  logic [8:0] LEN_OUT;
  logic [31:0] HDR_OUT;
  int miscompares = 0;
  int checked = 0;
  always #50 CLK = ~CLK;
  hso_sparsifier #(.LATENCY(LAT), .DATA_DEPTH(DEPTH)) dut (
    .CLK(CLK), .RESET(RESET), .FRAME_START(FRAME_START), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE(SAMPLE), .THRESHOLD(THRESHOLD), .CHAN_ID(CHAN_ID), .HISTORY(HISTORY),
    .DATA_POP(DATA_POP), .LEN_POP(LEN_POP), .HDR_POP(HDR_POP), .DATA_OUT(DATA_OUT),
    .DATA_EMPTY(DATA_EMPTY), .LEN_OUT(LEN_OUT), .LEN_EMPTY(LEN_EMPTY), .HDR_OUT(HDR_OUT),
    .HDR_EMPTY(HDR_EMPTY), .OVERFLOW(OVERFLOW)
  );
  hso_reader rd (
    .CLK(CLK), .LEN_OUT(LEN_OUT), .HDR_OUT(HDR_OUT), .DATA_OUT(DATA_OUT),
    .DATA_POP(DATA_POP), .LEN_POP(LEN_POP), .HDR_POP(HDR_POP)
  );
  ////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // channel c carries FF-c, so channels below FF-thr are hits
  task automatic send_frame(input logic [7:0] thr, input logic [7:0] hist);
    @(posedge CLK);
    FRAME_START <= 1'b1;
    SAMPLE_VALID <= 1'b1;
    THRESHOLD <= thr;
    HISTORY <= hist;
    for (int c = 0; c < 256; c++) begin
      SAMPLE <= 8'hFF - c[7:0];
      @(posedge CLK);
      FRAME_START <= 1'b0;
      HISTORY <= ~hist;
    end
    SAMPLE_VALID <= 1'b0;
    repeat (LAT + 10) @(posedge CLK);
  endtask : send_frame
  task automatic read_check(input logic [7:0] thr, input logic [7:0] hist);
    logic [8:0] n;
    logic [31:0] h;
    @(negedge CLK);
    chk("len_empty", 32'h0, {31'h0, LEN_EMPTY});
    chk("hdr_empty", 32'h0, {31'h0, HDR_EMPTY});
    rd.read_event(n, h);
    chk("length", 32'hFF - thr, n);
    chk("header", {CHAN_ID, 8'h00, `HSO_TYPE_ZERO_SUPPRESSED, hist}, h);
    for (int i = 0; i < n; i++) chk("hit", {i[7:0], 8'hFF - i[7:0]}, rd.words[i]);
  endtask : read_check
  // channel at the threshold itself must be dropped
  task automatic t_hits;
    send_frame(8'hFA, 8'h11);
    read_check(8'hFA, 8'h11);
  endtask : t_hits
  // two events held at once, the second with no hits
  task automatic t_multi;
    send_frame(8'hF0, 8'h22);
    send_frame(8'hFF, 8'h33);
    read_check(8'hF0, 8'h22);
    read_check(8'hFF, 8'h33);
    chk("data_empty", 32'h1, {31'h0, DATA_EMPTY});
    chk("overflow", 32'h0, {31'h0, OVERFLOW});
  endtask : t_multi
  // more hits than the data fifo holds: the first ones stay, status flags it
  task automatic t_overflow;
    logic [8:0] n;
    logic [31:0] h;
    send_frame(8'h00, 8'h44);
    @(negedge CLK);
    chk("overflow", 32'h1, {31'h0, OVERFLOW});
    rd.read_event(n, h);
    chk("ovf_length", DEPTH, n);
    chk("ovf_hdr", {CHAN_ID, `HSO_STATUS_OVERFLOW, `HSO_TYPE_ZERO_SUPPRESSED, 8'h44}, h);
    for (int i = 0; i < n; i++) chk("ovf_hit", {i[7:0], 8'hFF - i[7:0]}, rd.words[i]);
  endtask : t_overflow
  // reset in mid-run drops a pending overrun event, then frames work again
  task automatic t_reset;
    send_frame(8'h00, 8'h55);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(negedge CLK);
    chk("rst_data_empty", 32'h1, {31'h0, DATA_EMPTY});
    chk("rst_len_empty", 32'h1, {31'h0, LEN_EMPTY});
    chk("rst_hdr_empty", 32'h1, {31'h0, HDR_EMPTY});
    chk("rst_overflow", 32'h0, {31'h0, OVERFLOW});
    t_hits();
  endtask : t_reset
  task automatic stop_test;
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    t_hits();
    t_multi();
    t_overflow();
    t_reset();
    stop_test();
  end
  // about 3600 cycles expected
  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    stop_test();
  end
endmodule : test_hit_sparsifier_output_buffers
